// ---- rtl/prpc_regs.v ----
// paged register bank with power-down, reset and non-volatile load control
`timescale 1ns/100ps
`default_nettype none
`include "prpc_map.vh"

//////////////////////////////////////////////////////////////////////////////
module prpc_regs #(
    parameter NOUT = 7
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire reset_pin_low_i,
    input wire acc_wr_i,
    input wire acc_rd_i,
    input wire [7:0] acc_addr_i,
    input wire [7:0] acc_wdata_i,
    input wire preprogrammed_i,
    input wire nvm_load_valid_i,
    input wire [15:0] nvm_load_addr_i,
    input wire [7:0] nvm_load_data_i,
    input wire nvm_load_done_i,
    input wire burn_i,
    input wire nvm_burn_done_i,
    output reg [7:0] acc_rdata_o,
    output reg acc_rvalid_o,
    output reg global_power_down_o,
    output reg [NOUT-1:0] output_off_o,
    output reg align_o,
    output reg nvm_load_req_o,
    output reg nvm_burn_req_o,
    output reg xtal_48m_o,
    output reg io_1v8_o,
    output reg [3:0] page_region_o
);

//////////////////////////////////////////////////////////////////////////////
localparam ST_LOAD = 2'b00;
localparam ST_RUN = 2'b01;
localparam ST_BURN = 2'b10;
localparam ST_ALIGN = 2'b11;
localparam [7:0] OUT_OFF_RST = `PRPC_OUT_OFF_RST;

reg [1:0] state_q;
reg [1:0] state_d;
reg [7:0] page_q;
reg soft_rst_q;
reg pdn_q;
reg hrst_q;
reg all_off_q;
reg [NOUT-1:0] out_off_q;
reg [7:0] align_cnt_q;
reg pin_low_q;
reg ready_q;

wire [15:0] full_addr;
wire wr_en;
wire load_wr;
wire [15:0] wr_addr;
wire [7:0] wr_data;
wire [15:0] out_addr [0:NOUT-1];
wire reload_clr;

assign out_addr[0] = `PRPC_OUT0_ADDR;
assign out_addr[1] = `PRPC_OUT1_ADDR;
assign out_addr[2] = `PRPC_OUT2_ADDR;
assign out_addr[3] = `PRPC_OUT3_ADDR;
assign out_addr[4] = `PRPC_OUT4_ADDR;
assign out_addr[5] = `PRPC_OUT5_ADDR;
assign out_addr[6] = `PRPC_OUT6_ADDR;

// page and offset together form the 16-bit register address
assign full_addr = {page_q, acc_addr_i};
// memory load shares the write path so a reload overwrites host changes
assign load_wr = (state_q == ST_LOAD) && nvm_load_valid_i;
assign wr_en = ((state_q != ST_LOAD) && acc_wr_i) || load_wr;
assign wr_addr = load_wr ? nvm_load_addr_i : full_addr;
assign wr_data = load_wr ? nvm_load_data_i : acc_wdata_i;
// last run cycle before a hard reload: unsaved settings fall back to defaults
assign reload_clr = (state_q == ST_RUN) && hrst_q;

//////////////////////////////////////////////////////////////////////////////
always @*
begin
    state_d = state_q;
    case (state_q)
        ST_LOAD:
        begin
            if (nvm_load_done_i || !preprogrammed_i)
                state_d = ST_ALIGN;
        end
        ST_RUN:
        begin
            if (hrst_q)
                state_d = ST_LOAD;
            else if (soft_rst_q || pin_low_q)
                state_d = ST_ALIGN;
            else if (burn_i)
                state_d = ST_BURN;
        end
        ST_BURN:
        begin
            if (nvm_burn_done_i)
                state_d = ST_RUN;
        end
        ST_ALIGN:
        begin
            if (align_cnt_q == `PRPC_ALIGN_CYC)
                state_d = ST_RUN;
        end
        default:
        begin
            state_d = ST_RUN;
        end
    endcase
end

//////////////////////////////////////////////////////////////////////////////
// sequencer state and the realignment counter
always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        state_q <= ST_LOAD;
        align_cnt_q <= 8'h00;
        pin_low_q <= 1'b0;
        ready_q <= 1'b0;
    end
    else
    begin
        state_q <= state_d;
        pin_low_q <= !reset_pin_low_i;
        ready_q <= (state_d == ST_RUN);
        if (state_q == ST_ALIGN)
            align_cnt_q <= align_cnt_q + 8'h01;
        else
            align_cnt_q <= 8'h00;
    end
end

//////////////////////////////////////////////////////////////////////////////
// page select answers at the same offset on every page and survives a reload
always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
        page_q <= `PRPC_PAGE_RST;
    else if ((state_q != ST_LOAD) && acc_wr_i && (acc_addr_i == `PRPC_PAGE_SEL_OFS))
        page_q <= acc_wdata_i;
end

//////////////////////////////////////////////////////////////////////////////
// soft reset bit: a fresh write wins over the self-clear
always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
        soft_rst_q <= 1'b0;
    else if (wr_en && (wr_addr == `PRPC_SOFT_RST_ADDR))
        soft_rst_q <= wr_data[`PRPC_SRST_BIT];
    else if (state_q == ST_ALIGN)
        soft_rst_q <= 1'b0;
end

//////////////////////////////////////////////////////////////////////////////
// power bits and hard reset; the reload clear comes before the replayed image
always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        pdn_q <= 1'b0;
        hrst_q <= 1'b0;
        all_off_q <= 1'b0;
    end
    else
    begin
        if (reload_clr)
            pdn_q <= 1'b0;
        else if (wr_en && (wr_addr == `PRPC_PDN_HRST_ADDR))
            pdn_q <= wr_data[`PRPC_PDN_BIT];
        if (wr_en && (wr_addr == `PRPC_PDN_HRST_ADDR))
            hrst_q <= load_wr ? 1'b0 : wr_data[`PRPC_HRST_BIT];
        else if (state_q == ST_LOAD)
            hrst_q <= 1'b0;
        if (reload_clr)
            all_off_q <= 1'b0;
        else if (wr_en && (wr_addr == `PRPC_ALL_OFF_ADDR))
            all_off_q <= wr_data[`PRPC_OFF_BIT];
    end
end

// one flop per output power-down bit, reset to off for a blank part
genvar gi;
generate
    for (gi = 0; gi < NOUT; gi = gi + 1)
    begin : g_out
        always @(posedge clock_i or negedge rst_b_i)
        begin
            if (!rst_b_i)
                out_off_q[gi] <= OUT_OFF_RST[`PRPC_OFF_BIT];
            else if (reload_clr)
                out_off_q[gi] <= OUT_OFF_RST[`PRPC_OFF_BIT];
            else if (wr_en && (wr_addr == out_addr[gi]))
                out_off_q[gi] <= wr_data[`PRPC_OFF_BIT];
        end
    end
endgenerate

//////////////////////////////////////////////////////////////////////////////
always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        acc_rdata_o <= `PRPC_REG_RST;
        acc_rvalid_o <= 1'b0;
    end
    else
    begin
        // read answer is refused while the stored image is loading
        acc_rvalid_o <= acc_rd_i && (state_q != ST_LOAD);
        acc_rdata_o <= read_mux(acc_addr_i, full_addr);
    end
end

//////////////////////////////////////////////////////////////////////////////
// register port is untouched by power-down, only the drivers go off
always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        global_power_down_o <= 1'b0;
        output_off_o <= {NOUT{1'b1}};
    end
    else
    begin
        global_power_down_o <= pdn_q;
        output_off_o <= out_off_q | {NOUT{all_off_q | pdn_q}};
    end
end

//////////////////////////////////////////////////////////////////////////////
// sequencer indications towards the clock paths and the stored image
always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        align_o <= 1'b0;
        nvm_load_req_o <= 1'b0;
        nvm_burn_req_o <= 1'b0;
    end
    else
    begin
        align_o <= (state_q == ST_ALIGN);
        nvm_load_req_o <= (state_q == ST_LOAD) && preprogrammed_i;
        nvm_burn_req_o <= (state_q == ST_BURN);
    end
end

//////////////////////////////////////////////////////////////////////////////
// strap defaults and the page region code
always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        xtal_48m_o <= `PRPC_XTAL_48M;
        io_1v8_o <= `PRPC_IO_1V8;
        page_region_o <= 4'h0;
    end
    else
    begin
        xtal_48m_o <= `PRPC_XTAL_48M;
        io_1v8_o <= `PRPC_IO_1V8;
        page_region_o <= region(page_q);
    end
end

//////////////////////////////////////////////////////////////////////////////
function [7:0] read_mux;
    input [7:0] ofs;
    input [15:0] fa;
    integer k;
    begin
        read_mux = 8'h00;
        if (ofs == `PRPC_PAGE_SEL_OFS)
            read_mux = page_q;
        else if (ofs == `PRPC_READY_OFS)
            read_mux[`PRPC_READY_BIT] = ready_q;
        else if (fa == `PRPC_SOFT_RST_ADDR)
            read_mux[`PRPC_SRST_BIT] = soft_rst_q;
        else if (fa == `PRPC_PDN_HRST_ADDR)
            read_mux = {6'h00, hrst_q, pdn_q};
        else if (fa == `PRPC_ALL_OFF_ADDR)
            read_mux[`PRPC_OFF_BIT] = all_off_q;
        for (k = 0; k < NOUT; k = k + 1)
            if (fa == out_addr[k])
                read_mux[`PRPC_OFF_BIT] = out_off_q[k];
    end
endfunction

// region code: 0 alarms, 1 outputs, 2 dividers, 3 updates, 4 plls,
// 9 control io, a enables, b clocks, f undefined page
function [3:0] region;
    input [7:0] pg;
    begin
        case (pg)
            `PRPC_PAGE_ALARMS: region = 4'h0;
            `PRPC_PAGE_OUTPUTS: region = 4'h1;
            `PRPC_PAGE_DIVIDERS: region = 4'h2;
            `PRPC_PAGE_UPDATES: region = 4'h3;
            `PRPC_PAGE_CTRL_IO: region = 4'h9;
            `PRPC_PAGE_DIV_EN: region = 4'ha;
            `PRPC_PAGE_INT_CLK: region = 4'hb;
            default:
                region = ((pg >= `PRPC_PAGE_PLL_LO) && (pg <= `PRPC_PAGE_PLL_HI)) ? 4'h4 : 4'hf;
        endcase
    end
endfunction

endmodule
`default_nettype wire

// ---- common/prpc_map.vh ----
// address map, field positions and reset values of the paged register bank
`ifndef PRPC_MAP_VH
`define PRPC_MAP_VH
`define PRPC_PAGE_SEL_OFS 8'h01
`define PRPC_READY_OFS 8'hfe
`define PRPC_SOFT_RST_ADDR 16'h001c
`define PRPC_PDN_HRST_ADDR 16'h001e
`define PRPC_ALL_OFF_ADDR 16'h0145
`define PRPC_OUT0_ADDR 16'h0112
`define PRPC_OUT1_ADDR 16'h0117
`define PRPC_OUT2_ADDR 16'h011c
`define PRPC_OUT3_ADDR 16'h0126
`define PRPC_OUT4_ADDR 16'h012b
`define PRPC_OUT5_ADDR 16'h0130
`define PRPC_OUT6_ADDR 16'h013a
`define PRPC_PDN_BIT 0
`define PRPC_HRST_BIT 1
`define PRPC_SRST_BIT 0
`define PRPC_OFF_BIT 0
`define PRPC_READY_BIT 0
`define PRPC_PAGE_RST 8'h00
`define PRPC_REG_RST 8'h00
`define PRPC_OUT_OFF_RST 8'h01
`define PRPC_XTAL_48M 1'b1
`define PRPC_IO_1V8 1'b1
`define PRPC_ALIGN_CYC 8'h08
`define PRPC_PAGE_ALARMS 8'h00
`define PRPC_PAGE_OUTPUTS 8'h01
`define PRPC_PAGE_DIVIDERS 8'h02
`define PRPC_PAGE_UPDATES 8'h03
`define PRPC_PAGE_PLL_LO 8'h04
`define PRPC_PAGE_PLL_HI 8'h07
`define PRPC_PAGE_CTRL_IO 8'h09
`define PRPC_PAGE_DIV_EN 8'h0a
`define PRPC_PAGE_INT_CLK 8'h0b
`endif

// ---- tb/prpc_regs_props.sv ----
// assertion checker for the paged register bank ports
`timescale 1ns/100ps
`default_nettype none
module prpc_regs_props (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic reset_pin_low_i,
    input wire logic acc_rd_i,
    input wire logic burn_i,
    input wire logic acc_rvalid_o,
    input wire logic global_power_down_o,
    input wire logic [6:0] output_off_o,
    input wire logic align_o,
    input wire logic nvm_load_req_o,
    input wire logic nvm_burn_req_o,
    input wire logic xtal_48m_o,
    input wire logic io_1v8_o,
    input wire logic [3:0] page_region_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    pdn_all_off_a: assert property (global_power_down_o |-> &output_off_o)
        else $error("outputs on in power-down");
    pdn_port_a: assert property (
        global_power_down_o && acc_rd_i && !nvm_load_req_o |=> acc_rvalid_o)
        else $error("no read answer in power-down");
    straps_a: assert property (xtal_48m_o && io_1v8_o)
        else $error("strap defaults lost");
    region_code_a: assert property (
        page_region_o inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'ha, 4'hb, 4'hf})
        else $error("bad region code");
    pin_align_a: assert property (
        !reset_pin_low_i && !nvm_load_req_o && !nvm_burn_req_o |-> ##[1:3] align_o)
        else $error("pin low without align");
    align_len_a: assert property ($rose(align_o) |-> align_o[*8])
        else $error("align too short");
    burn_req_a: assert property (burn_i |-> ##[1:2] nvm_burn_req_o)
        else $error("burn not started");
    load_quiet_a: assert property (nvm_load_req_o && $past(nvm_load_req_o) |-> !acc_rvalid_o)
        else $error("read answered during load");
endmodule
bind prpc_regs prpc_regs_props u_props (.clock_i, .rst_b_i, .reset_pin_low_i, .acc_rd_i, .burn_i,
    .acc_rvalid_o, .global_power_down_o, .output_off_o, .align_o, .nvm_load_req_o,
    .nvm_burn_req_o, .xtal_48m_o, .io_1v8_o, .page_region_o);
`default_nettype wire

// ---- tb/prpc_nvm_model.sv ----
// non-volatile store stand-in: loads one saved register, acknowledges burns
`timescale 1ns/100ps
`default_nettype none
module prpc_nvm_model (
    input wire logic clock_i,
    input wire logic load_req_i,
    input wire logic burn_req_i,
    output logic valid_o,
    output logic [15:0] addr_o,
    output logic [7:0] data_o,
    output logic done_o,
    output logic burn_done_o
);
    logic [2:0] step_q = 3'h0;
    logic [1:0] bstep_q = 2'h0;
    initial {valid_o, addr_o, data_o, done_o, burn_done_o} = '0;
    always @(posedge clock_i)
    begin
        step_q <= load_req_i ? step_q + 3'h1 : 3'h0;
        bstep_q <= burn_req_i ? bstep_q + 2'h1 : 2'h0;
        valid_o <= (step_q == 3'h2);
        // saved image keeps output0 on; idle bus flips so stale data is never reused
        addr_o <= (step_q == 3'h2) ? 16'h0112 : ~addr_o;
        data_o <= (step_q == 3'h2) ? 8'h00 : ~data_o;
        done_o <= (step_q == 3'h4);
        burn_done_o <= (bstep_q == 2'h2);
    end
endmodule
`default_nettype wire

// ---- tb/paged_register_power_control_tb_top.sv ----
// self-checking bench for the paged register bank
`timescale 1ns/100ps
`default_nettype none
module paged_register_power_control_tb_top;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic pin_b = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic preprog = 1'b0;
    logic burn = 1'b0;
    logic lv, ld, bd, rv, global_power_down, aln, lreq, breq, x48, io18;
    logic [15:0] la;
    logic [7:0] ldat, rdata, d;
    logic [6:0] off;
    logic [3:0] rgn;
    int err_count = 0;
    int compares = 0;
    always #12.5 clock_i = ~clock_i;
    prpc_regs u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .reset_pin_low_i(pin_b),
        .acc_wr_i(wr), .acc_rd_i(rd), .acc_addr_i(addr), .acc_wdata_i(wdata),
        .preprogrammed_i(preprog), .nvm_load_valid_i(lv), .nvm_load_addr_i(la),
        .nvm_load_data_i(ldat), .nvm_load_done_i(ld), .burn_i(burn), .nvm_burn_done_i(bd),
        .acc_rdata_o(rdata), .acc_rvalid_o(rv), .global_power_down_o(global_power_down), .output_off_o(off),
        .align_o(aln), .nvm_load_req_o(lreq), .nvm_burn_req_o(breq), .xtal_48m_o(x48),
        .io_1v8_o(io18), .page_region_o(rgn));
    prpc_nvm_model u_nvm (.clock_i(clock_i), .load_req_i(lreq), .burn_req_i(breq), .valid_o(lv),
        .addr_o(la), .data_o(ldat), .done_o(ld), .burn_done_o(bd));
    ////////////////////////////////////////////////////////////
    task automatic test_done;
    begin
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    begin
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    end
    endtask
    // outputs follow the register a cycle late, so settle two edges
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    begin
        @(posedge clock_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clock_i);
        wr <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
    end
    endtask
    task automatic rd_reg(input logic [7:0] a);
    begin
        @(posedge clock_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
        d = rv ? rdata : 8'hxx;
    end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    begin
        rd_reg(a);
        chk(what, exp, d);
    end
    endtask
    // refused reads during load come back unknown and keep the poll going
    task automatic wait_ready;
    begin
        for (int i = 0; i < 100; i++)
        begin
            rd_reg(8'hfe);
            if (d[0] === 1'b1)
                return;
        end
        chk("ready", 8'h01, d);
        test_done();
    end
    endtask
    initial
    begin
        repeat (2) @(posedge clock_i);
        rst_b_i <= 1'b1;
        wait_ready();
        chk("outs", 8'h7f, {1'b0, off});
        chk("straps", 8'h03, {6'h00, x48, io18});
        rd_chk("page", 8'h01, 8'h00);
        wr_reg(8'h01, 8'h01);
        wr_reg(8'h12, 8'h00);
        wr_reg(8'h17, 8'h00);
        chk("outs", 8'h7c, {1'b0, off});
        rd_chk("out0", 8'h12, 8'h00);
        rd_chk("page", 8'h01, 8'h01);
        rd_reg(8'hfe);
        chk("ready", 8'h01, {7'h00, d[0]});
        wr_reg(8'h45, 8'h01);
        chk("outs", 8'h7f, {1'b0, off});
        wr_reg(8'h45, 8'h00);
        chk("outs", 8'h7c, {1'b0, off});
        wr_reg(8'h01, 8'h00);
        wr_reg(8'h1e, 8'h01);
        chk("pdn", 8'h01, {7'h00, global_power_down});
        rd_chk("pdn reg", 8'h1e, 8'h01);
        wr_reg(8'h1e, 8'h00);
        wr_reg(8'h1c, 8'h01);
        chk("align", 8'h01, {7'h00, aln});
        wait_ready();
        rd_chk("soft", 8'h1c, 8'h00);
        @(posedge clock_i);
        pin_b <= 1'b0;
        @(posedge clock_i);
        pin_b <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        chk("align", 8'h01, {7'h00, aln});
        wait_ready();
        for (int p = 0; p < 12; p++)
        begin
            wr_reg(8'h01, p[7:0]);
            chk("region", (p == 8) ? 8'h0f : (p > 3 && p < 8) ? 8'h04 : p[7:0], {4'h0, rgn});
        end
        wr_reg(8'h01, 8'h00);
        @(posedge clock_i);
        preprog <= 1'b1;
        wr_reg(8'h1e, 8'h02);
        wait_ready();
        chk("outs", 8'h7e, {1'b0, off});
        rd_chk("hard", 8'h1e, 8'h00);
        @(posedge clock_i);
        burn <= 1'b1;
        @(posedge clock_i);
        burn <= 1'b0;
        @(posedge clock_i);
        #1;
        chk("burn", 8'h01, {7'h00, breq});
        repeat (8) @(posedge clock_i);
        #1;
        chk("burn", 8'h00, {7'h00, breq});
        test_done();
    end
endmodule
`default_nettype wire
